// file: rtl/cid_core.sv
// Fetch, decode and execute sequencer for the closing instruction group
// Contract
// - The trap opcode bumps PC, pushes PC low, PC high, index low, accumulator, flags, sets the mask and loads the vector in 9 cycles.
// - Test-negative-or-zero on accumulator, index low or memory clears V, sets N and Z, keeps other flags, the stack form taking 4 cycles.
// - Stack 8-bit offset mode addresses stack pointer plus an unsigned byte.
// - Stack 16-bit offset mode addresses stack pointer plus a two-byte offset.
// - Indexed post-increment mode accesses at the index and then increments it.
// - Indexed 8-bit offset post-increment mode adds a byte to the index then increments the index.
// - Direct-to-indexed move reads a direct byte, writes it at the index, then increments the index.
// - Indexed-to-direct move reads at the index, writes to the direct address, then increments the index.
// - Immediate-to-direct move fetches a data byte and a direct address and writes the byte there.
// - Direct-to-direct move reads the first direct address and writes the second.
// - Absolute mode fetches the address high byte first then low byte.
// - Indexed 16-bit offset mode adds a high-then-low offset to the index.
// - Branches add one signed offset byte to the program counter.
// - A separate upper index byte joins the lower byte to form the 16-bit index.
`timescale 1ns/1ns
`include "cid_defines.svh"
module cid_core (
    input wire logic clk, // 100 MHz clock
    input wire logic arst_n, // Asynchronous reset, active low
    output logic [15:0] memAddr, // Memory address
    output logic memRead, // Memory read strobe
    output logic memWrite, // Memory write strobe
    output logic [7:0] memWdata, // Write data
    input wire logic [7:0] memRdata, // Read data, valid same cycle
    output logic [7:0] acc, // Accumulator
    output logic [15:0] index, // Upper:lower index
    output logic [15:0] sp, // Stack pointer
    output logic [15:0] pc, // Program counter
    output logic [7:0] flags, // Condition flags
    output logic instrDone // Pulse at last cycle of an instruction
);
    cid_pkg::cid_state_t state, next_state;
    cid_pkg::cid_mode_t mode, next_mode;
    logic [7:0] opcode, next_opcode, opHi, next_opHi, opLo, next_opLo, data, next_data;
    logic [7:0] next_acc, next_flags, idxHi, idxLo, next_idxHi, next_idxLo;
    logic [15:0] next_sp, next_pc, ea;
    logic [2:0] pushCnt, next_pushCnt;
    logic [3:0] cyc, next_cyc, waitCnt, next_waitCnt;
    logic [1:0] opCnt, next_opCnt;
    logic isTst, prefixed, next_prefixed;

    assign index = {idxHi, idxLo};

    cid_addr_gen addrGen (
        .mode(mode),
        .index(index),
        .sp(sp),
        .pc(pc),
        .opHi(opHi),
        .opLo(opLo),
        .ea(ea)
    );

    // Memory-operand test opcodes share one flag update
    assign isTst = (opcode == `CID_OP_TSTD) || (opcode == `CID_OP_TSTIX1)
        || (opcode == `CID_OP_TSTIX);

    // Sequencer next state
    always_comb begin
        next_state = state;
        next_mode = mode;
        next_opcode = opcode;
        next_opHi = opHi;
        next_opLo = opLo;
        next_data = data;
        next_acc = acc;
        next_flags = flags;
        next_idxHi = idxHi;
        next_idxLo = idxLo;
        next_sp = sp;
        next_pc = pc;
        next_pushCnt = pushCnt;
        next_waitCnt = waitCnt;
        next_opCnt = opCnt;
        next_prefixed = prefixed;
        next_cyc = cyc + 4'd1;
        memAddr = pc;
        memRead = 1'b0;
        memWrite = 1'b0;
        memWdata = 8'h00;
        instrDone = 1'b0;
        case (state)
            cid_pkg::FETCH, cid_pkg::PREFIX: begin
                memRead = 1'b1;
                next_opcode = memRdata;
                next_pc = pc + 16'h0001;
                next_cyc = (state == cid_pkg::PREFIX) ? cyc + 4'd1 : 4'd1; // Prefix byte counts
                next_prefixed = (state == cid_pkg::PREFIX);
                next_opCnt = 2'd0;
                next_waitCnt = 4'd0;
                next_state = cid_pkg::IDLE;
                if (state == cid_pkg::FETCH && memRdata == `CID_OP_PREFIX) begin
                    next_state = cid_pkg::PREFIX;
                end else if (state == cid_pkg::PREFIX) begin
                    next_mode = (memRdata == `CID_OP_TSTIX1) ? cid_pkg::M_SPB : cid_pkg::M_SPW;
                    next_opCnt = (memRdata == `CID_OP_TSTIX1) ? 2'd1 : 2'd2;
                    next_state = cid_pkg::OPND1;
                end else begin
                    case (memRdata)
                        `CID_OP_TRAP: begin
                            next_pushCnt = 3'd0;
                            next_state = cid_pkg::PUSH;
                        end
                        `CID_OP_TSTD: begin next_mode = cid_pkg::M_DIR; next_opCnt = 2'd1; end
                        `CID_OP_TSTIX1: begin next_mode = cid_pkg::M_IXB; next_opCnt = 2'd1; end
                        `CID_OP_TSTIX: next_mode = cid_pkg::M_IX;
                        `CID_OP_CBEQIX1P: begin next_mode = cid_pkg::M_IX1P; next_opCnt = 2'd1; end
                        `CID_OP_CBEQIXP: next_mode = cid_pkg::M_IXP;
                        `CID_OP_MOVDD: begin next_mode = cid_pkg::M_DDIR; next_opCnt = 2'd2; end
                        `CID_OP_MOVDIX: begin next_mode = cid_pkg::M_DIXP; next_opCnt = 2'd1; end
                        `CID_OP_MOVIMD: begin next_mode = cid_pkg::M_IMMD; next_opCnt = 2'd2; end
                        `CID_OP_MOVIXD: begin next_mode = cid_pkg::M_IXPD; next_opCnt = 2'd1; end
                        `CID_OP_LDAEXT: begin next_mode = cid_pkg::M_ABS; next_opCnt = 2'd2; end
                        `CID_OP_LDAIX2: begin next_mode = cid_pkg::M_IXW; next_opCnt = 2'd2; end
                        `CID_OP_BRA: begin next_mode = cid_pkg::M_REL; next_opCnt = 2'd1; end
                        default: next_mode = cid_pkg::M_IMPL;
                    endcase
                    if (memRdata != `CID_OP_TRAP && next_opCnt != 2'd0) begin
                        next_state = cid_pkg::OPND1;
                    end else if (memRdata != `CID_OP_TRAP && next_mode != cid_pkg::M_IMPL) begin
                        next_state = cid_pkg::READ;
                    end
                end
            end
            cid_pkg::OPND1, cid_pkg::OPND2: begin
                // Operand bytes, high first then low
                memRead = 1'b1;
                next_pc = pc + 16'h0001;
                next_opCnt = opCnt - 2'd1;
                if (opCnt == 2'd2) begin
                    next_opHi = memRdata;
                    next_state = cid_pkg::OPND2;
                end else begin
                    next_opLo = memRdata;
                    next_state = (mode == cid_pkg::M_IMMD) ? cid_pkg::WRITE : cid_pkg::READ;
                    if (mode == cid_pkg::M_REL) begin
                        next_state = cid_pkg::IDLE;
                    end
                    if (mode == cid_pkg::M_IMMD) begin
                        next_data = opHi;
                    end
                end
            end
            cid_pkg::READ: begin
                memRead = 1'b1;
                // Direct sources read the page address, the rest the formed address
                memAddr = ea;
                if (mode == cid_pkg::M_DDIR) begin
                    memAddr = {8'h00, opHi};
                end else if (mode == cid_pkg::M_DIXP) begin
                    memAddr = {8'h00, opLo};
                end
                next_data = memRdata;
                next_state = cid_pkg::IDLE;
                if (mode == cid_pkg::M_DDIR || mode == cid_pkg::M_DIXP || mode == cid_pkg::M_IXPD) begin
                    next_state = cid_pkg::WRITE;
                end
                if (isTst) begin
                    next_flags[`CID_FLAG_V] = 1'b0;
                    next_flags[`CID_FLAG_N] = memRdata[7];
                    next_flags[`CID_FLAG_Z] = (memRdata == 8'h00);
                end else if (mode == cid_pkg::M_ABS || mode == cid_pkg::M_IXW
                        || mode == cid_pkg::M_SPW) begin
                    next_acc = memRdata;
                end
            end
            cid_pkg::WRITE: begin
                memWrite = 1'b1;
                memWdata = data;
                memAddr = (mode == cid_pkg::M_DIXP) ? index : {8'h00, opLo};
                next_state = cid_pkg::IDLE;
            end
            cid_pkg::PUSH: begin
                // Stack order: PC low, PC high, index low, acc, flags
                memWrite = 1'b1;
                memAddr = sp;
                case (pushCnt)
                    3'd0: memWdata = pc[7:0];
                    3'd1: memWdata = pc[15:8];
                    3'd2: memWdata = idxLo;
                    3'd3: memWdata = acc;
                    default: memWdata = flags;
                endcase
                next_sp = sp - 16'h0001;
                next_pushCnt = pushCnt + 3'd1;
                if (pushCnt == 3'd4) begin
                    next_flags[`CID_FLAG_I] = 1'b1;
                    next_state = cid_pkg::VECHI;
                end
            end
            cid_pkg::VECHI: begin
                memRead = 1'b1;
                memAddr = `CID_VEC_HI;
                next_pc = {memRdata, pc[7:0]};
                next_state = cid_pkg::VECLO;
            end
            cid_pkg::VECLO: begin
                memRead = 1'b1;
                memAddr = `CID_VEC_LO;
                next_pc = {pc[15:8], memRdata};
                next_state = cid_pkg::IDLE;
            end
            cid_pkg::IDLE: begin
                // Execute and pad to the documented cycle count
                next_state = cid_pkg::FETCH;
                instrDone = 1'b1;
                if (opcode == `CID_OP_TRAP && cyc < `CID_TRAP_CYCLES) begin
                    next_state = cid_pkg::IDLE;
                    instrDone = 1'b0;
                end else if (prefixed && isTst && cyc < `CID_TST_SP1_CYCLES) begin
                    next_state = cid_pkg::IDLE;
                    instrDone = 1'b0;
                end else if ((opcode == `CID_OP_FLAGS_LOAD || opcode == `CID_OP_STK_TO_IDX
                        || opcode == `CID_OP_IDX_TO_STK) && cyc < `CID_XFER_TWO_CYCLES) begin
                    next_state = cid_pkg::IDLE;
                    instrDone = 1'b0;
                end
                if (instrDone) begin
                    if (mode == cid_pkg::M_REL) next_pc = ea;
                    if (mode == cid_pkg::M_IXP || mode == cid_pkg::M_IX1P || mode == cid_pkg::M_DIXP
                            || mode == cid_pkg::M_IXPD) begin
                        {next_idxHi, next_idxLo} = index + 16'h0001;
                    end
                    if (!prefixed) begin
                        case (opcode)
                            `CID_OP_TSTA, `CID_OP_TSTX: begin
                                next_flags[`CID_FLAG_V] = 1'b0;
                                next_flags[`CID_FLAG_N] = (opcode == `CID_OP_TSTA) ? acc[7] : idxLo[7];
                                next_flags[`CID_FLAG_Z] = (opcode == `CID_OP_TSTA) ? (acc == 8'h00)
                                    : (idxLo == 8'h00);
                            end
                            `CID_OP_FLAGS_LOAD: next_flags = acc | `CID_FLAG_FIXED;
                            `CID_OP_FLAGS_READ: next_acc = flags;
                            `CID_OP_ACC_TO_XLO: next_idxLo = acc;
                            `CID_OP_XLO_TO_ACC: next_acc = idxLo;
                            `CID_OP_STK_TO_IDX: {next_idxHi, next_idxLo} = sp + 16'h0001;
                            `CID_OP_IDX_TO_STK: next_sp = index - 16'h0001;
                            default: next_acc = acc;
                        endcase
                    end
                end
            end
            default: next_state = cid_pkg::FETCH;
        endcase
    end

    // State registers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= cid_pkg::FETCH;
            mode <= cid_pkg::M_IMPL;
            opcode <= 8'h00;
            opHi <= 8'h00;
            opLo <= 8'h00;
            data <= 8'h00;
            acc <= 8'h00;
            flags <= `CID_FLAGS_RESET;
            idxHi <= 8'h00;
            idxLo <= 8'h00;
            sp <= `CID_SP_RESET;
            pc <= `CID_PC_RESET;
            pushCnt <= 3'd0;
            waitCnt <= 4'd0;
            opCnt <= 2'd0;
            cyc <= 4'd0;
            prefixed <= 1'b0;
        end else begin
            state <= next_state;
            mode <= next_mode;
            opcode <= next_opcode;
            opHi <= next_opHi;
            opLo <= next_opLo;
            data <= next_data;
            acc <= next_acc;
            flags <= next_flags;
            idxHi <= next_idxHi;
            idxLo <= next_idxLo;
            sp <= next_sp;
            pc <= next_pc;
            pushCnt <= next_pushCnt;
            waitCnt <= next_waitCnt;
            opCnt <= next_opCnt;
            cyc <= next_cyc;
            prefixed <= next_prefixed;
        end
    end

    // Checks
    trap_push_count_a: assert property (@(posedge clk) disable iff (!arst_n)
        (state == cid_pkg::FETCH && memRdata == `CID_OP_TRAP) |=> (state == cid_pkg::PUSH) [*5])
        else $error("trap did not push five bytes");
    trap_mask_set_a: assert property (@(posedge clk) disable iff (!arst_n)
        (state == cid_pkg::VECHI) |-> flags[`CID_FLAG_I]) else $error("mask not set on trap");
    trap_sp_drop_a: assert property (@(posedge clk) disable iff (!arst_n)
        (state == cid_pkg::PUSH) |=> (sp == $past(sp) - 16'h0001)) else $error("sp not lowered");
    tst_clears_v_a: assert property (@(posedge clk) disable iff (!arst_n)
        (state == cid_pkg::READ && isTst) |=> !flags[`CID_FLAG_V]) else $error("test left V set");
    tst_keeps_c_a: assert property (@(posedge clk) disable iff (!arst_n)
        (state == cid_pkg::READ && isTst) |=> $stable(flags[0])) else $error("test changed carry");
    postinc_index_a: assert property (@(posedge clk) disable iff (!arst_n)
        (instrDone && mode == cid_pkg::M_IXP) |=> (index == $past(index) + 16'h0001))
        else $error("index not incremented");
    stk_to_idx_a: assert property (@(posedge clk) disable iff (!arst_n)
        (instrDone && opcode == `CID_OP_STK_TO_IDX && !prefixed)
        |=> (index == $past(sp) + 16'h0001))
        else $error("stack to index wrong");
    flags_read_a: assert property (@(posedge clk) disable iff (!arst_n)
        (instrDone && opcode == `CID_OP_FLAGS_READ && !prefixed)
        |=> (acc == $past(flags)) && $stable(flags))
        else $error("flags to acc wrong");
    move_write_a: assert property (@(posedge clk) disable iff (!arst_n)
        (state == cid_pkg::WRITE && mode == cid_pkg::M_DIXP) |-> (memAddr == index))
        else $error("move wrote wrong address");
endmodule : cid_core

// file: rtl/cid_defines.svh
// Opcodes, flag positions, vectors and cycle counts for the instruction decoder
`ifndef CID_DEFINES_SVH
`define CID_DEFINES_SVH
`define CID_OP_TRAP 8'h83
`define CID_OP_FLAGS_LOAD 8'h84
`define CID_OP_FLAGS_READ 8'h85
`define CID_OP_TSTD 8'h3D
`define CID_OP_TSTA 8'h4D
`define CID_OP_TSTX 8'h5D
`define CID_OP_TSTIX1 8'h6D
`define CID_OP_TSTIX 8'h7D
`define CID_OP_ACC_TO_XLO 8'h97
`define CID_OP_XLO_TO_ACC 8'h9F
`define CID_OP_STK_TO_IDX 8'h95
`define CID_OP_IDX_TO_STK 8'h94
`define CID_OP_PREFIX 8'h9E
`define CID_OP_MOVDD 8'h4E
`define CID_OP_MOVDIX 8'h5E
`define CID_OP_MOVIMD 8'h6E
`define CID_OP_MOVIXD 8'h7E
`define CID_OP_LDAEXT 8'hC6
`define CID_OP_LDAIX2 8'hD6
`define CID_OP_LDASP2 8'hD6
`define CID_OP_CBEQIX1P 8'h61
`define CID_OP_CBEQIXP 8'h71
`define CID_OP_BRA 8'h20
`define CID_FLAG_V 7
`define CID_FLAG_I 3
`define CID_FLAG_N 2
`define CID_FLAG_Z 1
`define CID_FLAG_FIXED 8'h60
`define CID_VEC_HI 16'hFFFC
`define CID_VEC_LO 16'hFFFD
`define CID_SP_RESET 16'h00FF
`define CID_PC_RESET 16'h0000
`define CID_FLAGS_RESET 8'h68
`define CID_TRAP_CYCLES 4'd9
`define CID_TST_SP1_CYCLES 4'd4
`define CID_XFER_TWO_CYCLES 4'd2
`endif

// file: rtl/cid_pkg.sv
// Types shared by the instruction decoder files
package cid_pkg;
    typedef enum logic [9:0] {
        FETCH = 10'b00_0000_0001,
        OPND1 = 10'b00_0000_0010,
        OPND2 = 10'b00_0000_0100,
        READ = 10'b00_0000_1000,
        WRITE = 10'b00_0001_0000,
        PUSH = 10'b00_0010_0000,
        VECHI = 10'b00_0100_0000,
        VECLO = 10'b00_1000_0000,
        IDLE = 10'b01_0000_0000,
        PREFIX = 10'b10_0000_0000
    } cid_state_t;
    typedef enum logic [3:0] {
        M_IMPL, M_DIR, M_IX, M_IXB, M_SPB, M_SPW, M_IXP, M_IX1P,
        M_DDIR, M_DIXP, M_IMMD, M_IXPD, M_ABS, M_IXW, M_REL
    } cid_mode_t;
endpackage : cid_pkg

// file: rtl/cid_addr_gen.sv
// Effective address former for the operand addressing modes
`timescale 1ns/1ns
module cid_addr_gen (
    input wire cid_pkg::cid_mode_t mode, // Current addressing mode
    input wire logic [15:0] index, // Upper:lower index
    input wire logic [15:0] sp, // Stack pointer
    input wire logic [15:0] pc, // Program counter after operands
    input wire logic [7:0] opHi, // First of two operand bytes
    input wire logic [7:0] opLo, // Last or only operand byte
    output logic [15:0] ea // Effective address
);
    // Address by mode
    always_comb begin
        case (mode)
            cid_pkg::M_SPB: ea = sp + {8'h00, opLo};
            cid_pkg::M_SPW: ea = sp + {opHi, opLo};
            cid_pkg::M_IX, cid_pkg::M_IXP, cid_pkg::M_DIXP, cid_pkg::M_IXPD: ea = index;
            cid_pkg::M_IXB, cid_pkg::M_IX1P: ea = index + {8'h00, opLo};
            cid_pkg::M_ABS: ea = {opHi, opLo};
            cid_pkg::M_IXW: ea = index + {opHi, opLo};
            cid_pkg::M_REL: ea = pc + {{8{opLo[7]}}, opLo};
            default: ea = {8'h00, opLo};
        endcase
    end
endmodule : cid_addr_gen

// file: testbench/cid_mem_model.sv
// Program and data memory answering the decoder core bus
`timescale 1ns/1ns
module cid_mem_model (
    input wire logic clk, // Core clock
    input wire logic [15:0] memAddr, // Bus address
    input wire logic memRead, // Read strobe
    input wire logic memWrite, // Write strobe
    input wire logic [7:0] memWdata, // Write data
    output logic [7:0] memRdata // Read data
);
    logic [7:0] store [0:65535];
    logic [7:0] lastRd;
    // Clear memory before the bench loads it
    initial begin
        for (int i = 0; i < 65536; i++) begin
            store[i] = 8'h00;
        end
        lastRd = 8'h00;
    end
    // Same-cycle read; an idle bus shows the inverted last byte, never a stale copy
    always_comb begin
        memRdata = memRead ? store[memAddr] : ~lastRd;
    end
    // Writes land on the edge that closes the bus cycle
    always @(posedge clk) begin
        if (memWrite) begin
            store[memAddr] <= memWdata;
        end
        if (memRead) begin
            lastRd <= store[memAddr];
        end
    end
endmodule : cid_mem_model

// file: testbench/tb.sv
// Self-checking bench comparing the decoder core with a queued expectation model
`timescale 1ns/1ns
module tb;
    typedef struct {
        int cyc;
        logic [7:0] a;
        logic [15:0] x;
        logic [15:0] s;
        logic [15:0] p;
        logic [7:0] f;
        bit fc;
    } cid_exp_t;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [15:0] memAddr;
    logic memRead;
    logic memWrite;
    logic [7:0] memWdata;
    logic [7:0] memRdata;
    logic [7:0] acc;
    logic [15:0] index;
    logic [15:0] sp;
    logic [15:0] pc;
    logic [7:0] flags;
    logic instrDone;
    int n_fail = 0;
    int num_checks = 0;
    logic [31:0] seed = 32'h02a9_638a;
    cid_exp_t q[$];
    // Clock at 100 MHz
    always #5 clk = ~clk;
    cid_core uut (.clk(clk), .arst_n(arst_n), .memAddr(memAddr), .memRead(memRead),
        .memWrite(memWrite), .memWdata(memWdata), .memRdata(memRdata), .acc(acc),
        .index(index), .sp(sp), .pc(pc), .flags(flags), .instrDone(instrDone));
    cid_mem_model mem (.clk(clk), .memAddr(memAddr), .memRead(memRead),
        .memWrite(memWrite), .memWdata(memWdata), .memRdata(memRdata));
    // Verdict and end of run
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : finish_test
    // Compare one value and count it
    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    // Xorshift random source
    function automatic logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction : rnd
    // Overflow cleared, negative and zero from the tested byte, others kept
    function automatic logic [7:0] nzf(input logic [7:0] f, input logic [7:0] v);
        return (f & 8'h79) | {5'b00000, v[7], v == 8'h00, 1'b0};
    endfunction : nzf
    // Queue one expected instruction result
    task automatic ex(input int c, input logic [7:0] a, input logic [15:0] x,
        input logic [15:0] s, input logic [15:0] p, input logic [7:0] f, input bit fc);
        q.push_back('{c, a, x, s, p, f, fc});
    endtask : ex
    // Wait for one instruction to end and compare the state it leaves
    task automatic step(input cid_exp_t e);
        int cnt;
        cnt = 0;
        do begin
            @(negedge clk);
            cnt++;
        end while (instrDone !== 1'b1 && cnt < 40);
        check("instrDone", {15'h0000, instrDone}, 16'h0001);
        @(posedge clk);
        #1;
        // The opening fetch cycle is not counted, matching the core's cycle counter that starts after it
        if (e.cyc > 0) check("cycles", 16'(cnt - 1), 16'(e.cyc));
        check("acc", {8'h00, acc}, {8'h00, e.a});
        check("index", index, e.x);
        check("sp", sp, e.s);
        check("pc", pc, e.p);
        if (e.fc) check("flags", {8'h00, flags}, {8'h00, e.f});
    endtask : step
    // One reset, program load and full run of the instruction sequence
    task automatic run_pass();
        logic [7:0] r, m, t, d0, e0, ii, g, h, f1, f2, f3, f4;
        logic [15:0] x0, s0, sF;
        logic [7:0] lo [13];
        logic [7:0] hi [25];
        r = rnd();
        m = rnd();
        t = rnd();
        d0 = rnd();
        e0 = rnd();
        ii = rnd();
        g = rnd();
        h = rnd();
        f1 = r | 8'h60;
        f2 = nzf(f1, r);
        f3 = nzf(f2, m);
        f4 = nzf(f3 | 8'h08, t);
        x0 = {8'h01, r};
        s0 = x0 - 16'h0001;
        sF = s0 - 16'h0005;
        @(negedge clk);
        arst_n = 1'b0;
        #1;
        check("reset pc", pc, 16'h0000);
        check("reset sp", sp, 16'h00FF);
        check("reset acc flags", {acc, flags}, 16'h0068);
        check("reset index", index, 16'h0000);
        lo = '{8'hC6, 8'h10, 8'h00, 8'h84, 8'h4D, 8'h95, 8'h97, 8'h85, 8'h94, 8'h9E,
            8'h6D, 8'hC0, 8'h83};
        hi = '{8'h7D, 8'h71, 8'h00, 8'h61, 8'h05, 8'h00, 8'h5E, 8'h40, 8'h7E, 8'h41, 8'h6E,
            ii, 8'h42, 8'h4E, 8'h40, 8'h43, 8'hD6, 8'h01, 8'h23, 8'h9E, 8'hD6, 8'h01, 8'h00,
            8'h20, 8'h10};
        foreach (lo[i]) mem.store[i] = lo[i];
        foreach (hi[i]) mem.store[16'h2000 + i] = hi[i];
        mem.store[16'h1000] = r;
        mem.store[16'hFFFC] = 8'h20;
        mem.store[16'hFFFD] = 8'h00;
        mem.store[s0 + 16'h00C0] = m;
        mem.store[x0] = t;
        mem.store[16'h0040] = d0;
        mem.store[x0 + 16'h0003] = e0;
        mem.store[x0 + 16'h0127] = g;
        mem.store[sF + 16'h0100] = h;
        repeat (4) @(negedge clk);
        arst_n = 1'b1;
        ex(0, r, 16'h0000, 16'h00FF, 16'h0003, 8'h00, 0);
        ex(2, r, 16'h0000, 16'h00FF, 16'h0004, f1, 1);
        ex(0, r, 16'h0000, 16'h00FF, 16'h0005, f2, 1);
        ex(2, r, 16'h0100, 16'h00FF, 16'h0006, f2, 1);
        ex(0, r, x0, 16'h00FF, 16'h0007, f2, 1);
        ex(1, f2, x0, 16'h00FF, 16'h0008, f2, 1);
        ex(2, f2, x0, s0, 16'h0009, f2, 1);
        ex(4, f2, x0, s0, 16'h000C, f3, 1);
        ex(9, f2, x0, sF, 16'h2000, f3 | 8'h08, 1);
        ex(0, f2, x0, sF, 16'h2001, f4, 1);
        ex(0, f2, x0 + 16'h0001, sF, 16'h2002, 8'h00, 0);
        ex(0, f2, x0 + 16'h0001, sF, 16'h2003, 8'h00, 0);
        ex(0, f2, x0 + 16'h0002, sF, 16'h2005, 8'h00, 0);
        ex(0, f2, x0 + 16'h0002, sF, 16'h2006, 8'h00, 0);
        ex(0, f2, x0 + 16'h0003, sF, 16'h2008, 8'h00, 0);
        ex(0, f2, x0 + 16'h0004, sF, 16'h200A, 8'h00, 0);
        ex(0, f2, x0 + 16'h0004, sF, 16'h200D, 8'h00, 0);
        ex(0, f2, x0 + 16'h0004, sF, 16'h2010, 8'h00, 0);
        ex(0, g, x0 + 16'h0004, sF, 16'h2013, 8'h00, 0);
        ex(0, h, x0 + 16'h0004, sF, 16'h2017, 8'h00, 0);
        ex(0, h, x0 + 16'h0004, sF, 16'h2029, 8'h00, 0);
        while (q.size() > 0) step(q.pop_front());
        check("push pc low", {8'h00, mem.store[s0]}, 16'h000D);
        check("push pc high", {8'h00, mem.store[s0 - 16'h0001]}, 16'h0000);
        check("push index", {8'h00, mem.store[s0 - 16'h0002]}, {8'h00, r});
        check("push acc", {8'h00, mem.store[s0 - 16'h0003]}, {8'h00, f2});
        check("push flags", {8'h00, mem.store[s0 - 16'h0004]}, {8'h00, f3});
        check("move to index", {8'h00, mem.store[x0 + 16'h0002]}, {8'h00, d0});
        check("move to direct", {8'h00, mem.store[16'h0041]}, {8'h00, e0});
        check("move immediate", {8'h00, mem.store[16'h0042]}, {8'h00, ii});
        check("move direct", {8'h00, mem.store[16'h0043]}, {8'h00, d0});
    endtask : run_pass
    // Two passes, each resetting the core before running the whole sequence
    initial begin
        run_pass();
        run_pass();
        finish_test();
    end
    // Watchdog cuts a hang short
    initial begin
        #100000;
        n_fail++;
        $display("wrong value watchdog expected finish seen hang");
        finish_test();
    end
endmodule : tb
